// >>> src/fetch_sync_params.svh
`ifndef FETCH_SYNC_PARAMS_SVH
`define FETCH_SYNC_PARAMS_SVH

// register byte offsets on the apb side
`define REG_CTRL_OFS      8'h00
`define REG_STATUS_OFS    8'h04
`define REG_STALLS_OFS    8'h08

// control register fields
`define CTRL_ENABLE_BIT   0
`define CTRL_KILLCLR_BIT  1
`define CTRL_RESET        1'h1

// status register fields
`define ST_FLAG_BIT       0
`define ST_FLAG_VALID_BIT 1
`define ST_LOCK_BIT       2
`define ST_LOCK_SRC_BIT   3
`define ST_KILL_BIT       4
`define ST_TEX_CNT_LSB    8
`define ST_WR_CNT_LSB     16

// ieee single fields
`define FP_SIGN_BIT       31
`define FP_EXP_MSB        30
`define FP_EXP_LSB        23
`define FP_ONE            32'h3f800000

`endif

// >>> src/fetch_sync_pkg.sv
package fetch_sync_pkg;

   typedef enum logic [1:0] {
      CLASS_ALU  = 2'b00,
      CLASS_TEX  = 2'b01,
      CLASS_FLOW = 2'b10,
      CLASS_OUT  = 2'b11
   } inst_class_e;

   typedef enum logic [2:0] {
      FETCH_OP_IDLE              = 3'b000,
      FETCH_OP_SAMPLE            = 3'b001,
      FETCH_OP_DISCARD_NEGATIVE  = 3'b010,
      FETCH_OP_SAMPLE_PROJECTIVE = 3'b011,
      FETCH_OP_DIRECT_READ       = 3'b100
   } fetch_op_e;

   typedef enum logic [1:0] {
      CMP_IS_ZERO        = 2'b00,
      CMP_IS_NEGATIVE    = 2'b01,
      CMP_IS_NONNEGATIVE = 2'b10,
      CMP_IS_NONZERO     = 2'b11
   } cmp_op_e;

   typedef enum logic [2:0] {
      PRED_NONE = 3'b000,
      PRED_RGBA = 3'b001,
      PRED_RRRR = 3'b010,
      PRED_GGGG = 3'b011,
      PRED_BBBB = 3'b100,
      PRED_AAAA = 3'b101
   } pred_sel_e;

   typedef enum logic {
      LOCK_BY_FETCH = 1'b0,
      LOCK_BY_WRITE = 1'b1
   } lock_src_e;

endpackage

// >>> src/shader_fetch_sync.sv
`include "fetch_sync_params.svh"
// Contract
// (RL1) condition flag holds across instructions that do not write it
// (RL2) flow-control instruction consumes the flag once, then invalidates it
// (RL3) flag is one bit from red or alpha channel by select field
// (RL4) compare op tests zero, negative, non-negative or non-zero
// (RL5) flag updates only when the flag write enable bit is set
// (RL6) comparison uses the value after clamping
// (RL7) denormal inputs compare as zero
// (RL8) fetch decodes dest, one to three sources, sampler, op, control bits
// (RL9) loop index optionally added to source and destination addresses
// (RL10) swizzles pass through; they select channels only, sources are temps
// (RL11) colour and opacity masks gated by their own predicate fields
// (RL12) coords scaled by texture size unless prescaled bit set
// (RL13) idle op issues nothing yet may still take the lock
// (RL14) sample reads sources, writes dest; projective divides by q
// (RL15) discard op disables processor if any unmasked component below zero
// (RL16) direct read fetches data stored by earlier scatter writes
// (RL17) take bit holds the lock until fetched data is written back
// (RL18) stall bit waits while lock held; no added delay when free
// (RL19) one lock at a time; take implies wait, wait comes first
// (RL20) fetch lock released once that and all earlier lookups finish
// (RL21) write lock released once that and all earlier writes finish
// (RL22) program must end with stall bit set, never holding the lock
// (RL23) lock is one held flag set at issue, cleared on completion; here a count of owed completions, held while nonzero
module shader_fetch_sync
   import fetch_sync_pkg::*;
#(
   parameter int REG_W = 7,
   parameter int CNT_W = 4
) (
   // clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // apb slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic [31:0]             prdata,
   output logic                    pslverr,
   // instruction from the sequencer, held until taken
   input  wire logic               inst_valid,
   output logic                    inst_ready,
   input  wire logic [1:0]         inst_class,
   input  wire logic               fetch_lock_stall,
   input  wire logic               fetch_lock_take,
   // alu result and flag controls
   input  wire logic [31:0]        result_red,
   input  wire logic [31:0]        result_alpha,
   input  wire logic               result_clamp,
   input  wire logic               cond_flag_sel_alpha,
   input  wire logic [1:0]         cond_flag_compare_op,
   input  wire logic               cond_flag_write_enable,
   // texture instruction fields
   input  wire logic [2:0]         fetch_op,
   input  wire logic [REG_W-1:0]   fetch_dest_reg,
   input  wire logic [REG_W-1:0]   fetch_source_reg0,
   input  wire logic [REG_W-1:0]   fetch_source_reg1,
   input  wire logic [REG_W-1:0]   fetch_source_reg2,
   input  wire logic [1:0]         fetch_source_count,
   input  wire logic [3:0]         sampler_id,
   input  wire logic               coords_prescaled,
   input  wire logic               dest_add_loop,
   input  wire logic               source_add_loop,
   input  wire logic [REG_W-1:0]   loop_index_var,
   input  wire logic [7:0]         source_swizzle,
   input  wire logic [7:0]         result_swizzle,
   input  wire logic [2:0]         colour_write_mask,
   input  wire logic               opacity_write_mask,
   input  wire logic [2:0]         colour_predicate_select,
   input  wire logic               colour_predicate_invert,
   input  wire logic [2:0]         opacity_predicate_select,
   input  wire logic               opacity_predicate_invert,
   input  wire logic [3:0]         predicate_bits,
   input  wire logic [127:0]       discard_source_data,
   // flag toward flow control
   output logic                    branch_cond,
   output logic                    branch_cond_valid,
   // fetch unit request and completion
   output logic                    fetch_req_valid,
   input  wire logic               fetch_req_ready,
   output logic [2:0]              fetch_req_op,
   output logic [REG_W-1:0]        fetch_req_dest,
   output logic [REG_W-1:0]        fetch_req_src0,
   output logic [REG_W-1:0]        fetch_req_src1,
   output logic [REG_W-1:0]        fetch_req_src2,
   output logic [1:0]              fetch_req_src_count,
   output logic [3:0]              fetch_req_sampler,
   output logic                    fetch_req_scale,
   output logic                    fetch_req_project,
   output logic [7:0]              fetch_req_src_swizzle,
   output logic [7:0]              fetch_req_res_swizzle,
   output logic [2:0]              fetch_req_colour_mask,
   output logic                    fetch_req_opacity_mask,
   input  wire logic               fetch_done,
   // scatter write path
   output logic                    direct_scatter_write,
   input  wire logic               scatter_write_ready,
   input  wire logic               scatter_write_done,
   // processor disable
   output logic                    processor_disable
);

   // registered outputs
   logic               ready_q, flag_q, flag_valid_q, br_q, br_valid_q;
   logic               req_valid_q, scatter_q, kill_q, ctrl_en_q;
   logic [CNT_W-1:0]   tex_cnt_q, wr_cnt_q, lock_cnt_q;
   lock_src_e          lock_src_q;
   logic [31:0]        stall_cnt_q;
   logic               pready_q, pslverr_q;
   logic [31:0]        prdata_q;

   // handshake and decode
   logic               take, lock_held, want_lock, go, lookup;
   logic               is_alu, is_tex, is_flow, is_out;
   assign take      = inst_valid && ready_q;
   assign is_alu    = inst_class == CLASS_ALU;
   assign is_tex    = inst_class == CLASS_TEX;
   assign is_flow   = inst_class == CLASS_FLOW;
   assign is_out    = inst_class == CLASS_OUT;
   assign lock_held = lock_cnt_q != '0;
   assign lookup    = is_tex && (fetch_op == FETCH_OP_SAMPLE ||
                      fetch_op == FETCH_OP_SAMPLE_PROJECTIVE ||
                      fetch_op == FETCH_OP_DIRECT_READ);
   // a take without the stall bit still waits, so two locks never overlap
   assign want_lock = fetch_lock_stall || fetch_lock_take; // RL19
   assign go = ctrl_en_q && !(want_lock && lock_held) && // RL18
               !(is_tex && req_valid_q) && !(is_out && scatter_q);

   // ready is offered one cycle after the held request can go;
   // costs one cycle per instruction but keeps inst_ready a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= inst_valid && go && !ready_q; // RL18
      end
   end

   // condition source: channel select, clamp, denormal flush
   logic [31:0] chan;
   logic        raw_zero, raw_neg, c_zero, c_neg, cmp_hit;
   always_comb begin
      chan     = cond_flag_sel_alpha ? result_alpha : result_red; // RL3
      // exponent zero covers both zeros and every denormal
      raw_zero = chan[`FP_EXP_MSB:`FP_EXP_LSB] == '0; // RL7
      raw_neg  = chan[`FP_SIGN_BIT] && !raw_zero;
      // clamp to [0,1] folds negatives into zero; upper bound stays nonzero
      c_neg    = raw_neg && !result_clamp; // RL6
      c_zero   = raw_zero || (raw_neg && result_clamp); // RL6
      unique case (cmp_op_e'(cond_flag_compare_op)) // RL4
         CMP_IS_ZERO:        cmp_hit = c_zero;
         CMP_IS_NEGATIVE:    cmp_hit = c_neg;
         CMP_IS_NONNEGATIVE: cmp_hit = !c_neg;
         CMP_IS_NONZERO:     cmp_hit = !c_zero;
      endcase
   end

   // condition flag: written by alu, consumed and dropped by flow control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q       <= 1'b0;
         flag_valid_q <= 1'b0;
         br_q         <= 1'b0;
         br_valid_q   <= 1'b0;
      end else begin
         br_valid_q <= take && is_flow; // RL2
         if (take && is_flow) begin
            br_q         <= flag_q && flag_valid_q; // RL2
            flag_valid_q <= 1'b0; // RL2
         end else if (take && is_alu && cond_flag_write_enable) begin // RL5
            flag_q       <= cmp_hit;
            flag_valid_q <= 1'b1;
         end // RL1
      end
   end

   // predicate expansion, bit order r g b a
   function automatic logic [3:0] pred_vec(input logic [2:0] sel,
                                           input logic       inv,
                                           input logic [3:0] p);
      logic [3:0] v;
      v = 4'hf;
      unique case (sel)
         PRED_NONE: v = 4'hf;
         PRED_RGBA: v = p ^ {4{inv}};
         PRED_RRRR: v = {4{p[0] ^ inv}};
         PRED_GGGG: v = {4{p[1] ^ inv}};
         PRED_BBBB: v = {4{p[2] ^ inv}};
         PRED_AAAA: v = {4{p[3] ^ inv}};
         default:   v = 4'hf;
      endcase
      return v;
   endfunction

   logic [3:0] colour_pv, opacity_pv, eff_mask, below_zero;
   assign colour_pv  = pred_vec(colour_predicate_select,
                                colour_predicate_invert, predicate_bits);
   assign opacity_pv = pred_vec(opacity_predicate_select,
                                opacity_predicate_invert, predicate_bits);
   assign eff_mask   = {opacity_write_mask & opacity_pv[3], // RL11
                        colour_write_mask & colour_pv[2:0]}; // RL11

   // discard test per component; source swizzle deliberately unused here
   for (genvar i = 0; i < 4; i++) begin : g_below
      assign below_zero[i] = discard_source_data[32*i+31] &&
                             discard_source_data[32*i +: 31] != '0 &&
                             eff_mask[i]; // RL15
   end

   // relative addressing
   logic [REG_W-1:0] src_ofs, dst_ofs;
   assign src_ofs = source_add_loop ? loop_index_var : '0; // RL9
   assign dst_ofs = dest_add_loop ? loop_index_var : '0; // RL9

   // fetch request register, held until the fetch unit accepts it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_valid_q            <= 1'b0;
         fetch_req_op           <= '0;
         fetch_req_dest         <= '0;
         fetch_req_src0         <= '0;
         fetch_req_src1         <= '0;
         fetch_req_src2         <= '0;
         fetch_req_src_count    <= '0;
         fetch_req_sampler      <= '0;
         fetch_req_scale        <= 1'b0;
         fetch_req_project      <= 1'b0;
         fetch_req_src_swizzle  <= '0;
         fetch_req_res_swizzle  <= '0;
         fetch_req_colour_mask  <= '0;
         fetch_req_opacity_mask <= 1'b0;
      end else if (take && lookup) begin // RL14 RL16
         req_valid_q            <= 1'b1;
         fetch_req_op           <= fetch_op; // RL8
         fetch_req_dest         <= REG_W'(fetch_dest_reg + dst_ofs); // RL9
         fetch_req_src0         <= REG_W'(fetch_source_reg0 + src_ofs);
         fetch_req_src1         <= REG_W'(fetch_source_reg1 + src_ofs);
         fetch_req_src2         <= REG_W'(fetch_source_reg2 + src_ofs);
         fetch_req_src_count    <= fetch_source_count; // RL8
         fetch_req_sampler      <= sampler_id; // RL8
         fetch_req_scale        <= !coords_prescaled; // RL12
         fetch_req_project      <= fetch_op == FETCH_OP_SAMPLE_PROJECTIVE;
         // two-bit fields can only name r g b a, never a constant
         fetch_req_src_swizzle  <= source_swizzle; // RL10
         fetch_req_res_swizzle  <= result_swizzle; // RL10
         fetch_req_colour_mask  <= eff_mask[2:0]; // RL11
         fetch_req_opacity_mask <= eff_mask[3]; // RL11
      end else if (fetch_req_ready) begin
         req_valid_q <= 1'b0;
      end
   end

   // scatter write issue, held until the write path accepts it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scatter_q <= 1'b0;
      end else if (take && is_out) begin
         scatter_q <= 1'b1;
      end else if (scatter_write_ready) begin
         scatter_q <= 1'b0;
      end
   end

   // in-order completion counters for lookups and scatter writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tex_cnt_q <= '0;
         wr_cnt_q  <= '0;
      end else begin
         tex_cnt_q <= CNT_W'(tex_cnt_q + CNT_W'(take && lookup)
                      - CNT_W'(fetch_done));
         wr_cnt_q  <= CNT_W'(wr_cnt_q + CNT_W'(take && is_out)
                      - CNT_W'(scatter_write_done));
      end
   end

   // lock: nonzero count means held; the count is the completions still
   // owed by this and every earlier operation of the same kind
   logic [CNT_W-1:0] lock_new;
   always_comb begin
      if (is_out) begin
         lock_new = CNT_W'(wr_cnt_q + 1'b1 - CNT_W'(scatter_write_done));
      end else if (lookup) begin
         lock_new = CNT_W'(tex_cnt_q + 1'b1 - CNT_W'(fetch_done)); // RL17
      end else begin
         // idle or discard: waits only on lookups already in flight
         lock_new = CNT_W'(tex_cnt_q - CNT_W'(fetch_done)); // RL13
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_cnt_q <= '0;
         lock_src_q <= LOCK_BY_FETCH;
      end else if (take && fetch_lock_take && (is_tex || is_out)) begin
         lock_cnt_q <= lock_new; // RL23
         lock_src_q <= is_out ? LOCK_BY_WRITE : LOCK_BY_FETCH;
      end else if (lock_held && lock_src_q == LOCK_BY_FETCH && fetch_done) begin
         lock_cnt_q <= CNT_W'(lock_cnt_q - 1'b1); // RL20
      end else if (lock_held && lock_src_q == LOCK_BY_WRITE &&
                   scatter_write_done) begin
         lock_cnt_q <= CNT_W'(lock_cnt_q - 1'b1); // RL21
      end
   end

   // sticky processor disable; a kill in the clearing cycle wins
   logic kill_clr;
   assign kill_clr = psel && penable && pready_q && pwrite &&
                     paddr == `REG_CTRL_OFS && pwdata[`CTRL_KILLCLR_BIT];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         kill_q <= 1'b0;
      end else if (take && is_tex && fetch_op == FETCH_OP_DISCARD_NEGATIVE
                   && below_zero != '0) begin
         kill_q <= 1'b1; // RL15
      end else if (kill_clr) begin
         kill_q <= 1'b0;
      end
   end

   // cycles a stalling instruction sat behind the lock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_cnt_q <= '0;
      end else if (inst_valid && want_lock && lock_held) begin
         stall_cnt_q <= stall_cnt_q + 32'h1;
      end
   end

   // apb: one wait state, so read data and errors come from flops
   logic [31:0] rdata;
   logic        mapped;
   always_comb begin
      rdata  = '0;
      mapped = 1'b1;
      unique case (paddr)
         `REG_CTRL_OFS: rdata[`CTRL_ENABLE_BIT] = ctrl_en_q;
         `REG_STATUS_OFS: begin
            rdata[`ST_FLAG_BIT]       = flag_q;
            rdata[`ST_FLAG_VALID_BIT] = flag_valid_q;
            rdata[`ST_LOCK_BIT]       = lock_held;
            rdata[`ST_LOCK_SRC_BIT]   = lock_src_q;
            rdata[`ST_KILL_BIT]       = kill_q;
            rdata[`ST_TEX_CNT_LSB +: CNT_W] = tex_cnt_q;
            rdata[`ST_WR_CNT_LSB +: CNT_W]  = wr_cnt_q;
         end
         `REG_STALLS_OFS: rdata = stall_cnt_q;
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         prdata_q  <= '0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= psel && penable && !pready_q;
         if (psel && penable && !pready_q) begin
            prdata_q  <= pwrite ? 32'h0 : rdata;
            pslverr_q <= !mapped;
         end else begin
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
         end
      end
   end

   // software enable gates instruction acceptance
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_en_q <= `CTRL_RESET;
      end else if (psel && penable && pready_q && pwrite &&
                   paddr == `REG_CTRL_OFS) begin
         ctrl_en_q <= pwdata[`CTRL_ENABLE_BIT];
      end
   end

   // output wiring, all straight from flops
   assign pready               = pready_q;
   assign prdata               = prdata_q;
   assign pslverr              = pslverr_q;
   assign inst_ready           = ready_q;
   assign branch_cond          = br_q;
   assign branch_cond_valid    = br_valid_q;
   assign fetch_req_valid      = req_valid_q;
   assign direct_scatter_write = scatter_q;
   assign processor_disable    = kill_q;

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_flag_held_tex: assert property ( // RL1
      take && (is_tex || is_out) |=> $stable(flag_q) && $stable(flag_valid_q))
      else $error("flag changed on a non-writing instruction");

   a_flow_consumes: assert property ( // RL2
      take && is_flow |=> br_valid_q && !flag_valid_q &&
                         br_q == $past(flag_q && flag_valid_q))
      else $error("flow control did not consume and drop the flag");

   a_flag_needs_wen: assert property ( // RL5
      take && is_alu && !cond_flag_write_enable |=> $stable(flag_q))
      else $error("flag written without enable");

   a_neg_compare: assert property ( // RL4
      take && is_alu && cond_flag_write_enable && !result_clamp &&
      cond_flag_compare_op == CMP_IS_NEGATIVE && !cond_flag_sel_alpha &&
      result_red[31] && result_red[30:23] != '0 |=> flag_q)
      else $error("negative compare missed");

   a_denorm_zero: assert property ( // RL7
      take && is_alu && cond_flag_write_enable &&
      cond_flag_compare_op == CMP_IS_ZERO && cond_flag_sel_alpha &&
      result_alpha[30:23] == '0 |=> flag_q && flag_valid_q)
      else $error("denormal not treated as zero");

   a_stall_lock: assert property ( // RL18
      inst_valid && want_lock && lock_held |=> !ready_q)
      else $error("stalling instruction offered while lock held");

   a_free_no_delay: assert property ( // RL18
      inst_valid && !ready_q && ctrl_en_q && !lock_held && is_alu
      |=> ready_q ##1 !ready_q)
      else $error("free lock delayed an instruction");

   a_lock_release: assert property ( // RL20
      lock_cnt_q == 1 && lock_src_q == LOCK_BY_FETCH && fetch_done &&
      !(take && fetch_lock_take) |=> !lock_held)
      else $error("lock not released on last completion");

   a_idle_no_fetch: assert property ( // RL13
      take && is_tex && fetch_op == FETCH_OP_IDLE |=> !req_valid_q)
      else $error("idle op issued a fetch");

   a_discard_kill: assert property ( // RL15
      take && is_tex && fetch_op == FETCH_OP_DISCARD_NEGATIVE &&
      below_zero != '0 |=> kill_q [*2])
      else $error("discard did not disable processor");

endmodule

// >>> tb/done_model.sv
module done_model (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // request handshake and completion pulse
   input  wire logic       req,
   output logic            ack,
   output logic            done,
   // cycles from acceptance to completion
   input  wire logic [7:0] lat
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] n_q;
   logic [7:0] t_q;
   logic       fin;
   assign fin = (n_q != 4'h0) && (t_q == lat);
   // accept a cycle late; completions leave strictly in order
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack  <= 1'b0;
         done <= 1'b0;
         n_q  <= 4'h0;
         t_q  <= 8'h00;
      end else begin
         ack  <= req && !ack;
         done <= fin;
         n_q  <= n_q + 4'(req && ack) - 4'(fin);
         t_q  <= (fin || n_q == 4'h0) ? 8'h00 : t_q + 8'h01;
      end
   end
endmodule

// >>> tb/shader_fetch_sync_tb.sv
`include "fetch_sync_params.svh"
module shader_fetch_sync_tb
   import fetch_sync_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, inst_valid;
   logic inst_ready, fetch_lock_stall, fetch_lock_take, result_clamp;
   logic cond_flag_sel_alpha, cond_flag_write_enable, coords_prescaled;
   logic dest_add_loop, source_add_loop, opacity_write_mask, fetch_done;
   logic colour_predicate_invert, opacity_predicate_invert, fetch_req_ready;
   logic scatter_write_ready, scatter_write_done, branch_cond, fetch_req_scale;
   logic branch_cond_valid, fetch_req_valid, fetch_req_project;
   logic fetch_req_opacity_mask, direct_scatter_write, processor_disable;
   logic [1:0] inst_class, cond_flag_compare_op, fetch_source_count;
   logic [1:0] fetch_req_src_count;
   logic [2:0] fetch_op, colour_write_mask, colour_predicate_select;
   logic [2:0] opacity_predicate_select, fetch_req_op, fetch_req_colour_mask;
   logic [3:0] sampler_id, predicate_bits, fetch_req_sampler;
   logic [6:0] fetch_dest_reg, fetch_source_reg0, fetch_source_reg1;
   logic [6:0] fetch_source_reg2, loop_index_var, fetch_req_dest;
   logic [6:0] fetch_req_src0, fetch_req_src1, fetch_req_src2;
   logic [7:0] paddr, source_swizzle, result_swizzle, lf, ls;
   logic [7:0] fetch_req_src_swizzle, fetch_req_res_swizzle;
   logic [31:0] pwdata, prdata, result_red, result_alpha, rd;
   logic [127:0] discard_source_data;
   logic er;
   int bad_count = 0, n_compared = 0, w, dn = 0, sn = 0, cyc = 0;

   shader_fetch_sync DUT (.*);
   done_model fm (.pclk(pclk), .presetn(presetn), .req(fetch_req_valid),
      .ack(fetch_req_ready), .done(fetch_done), .lat(lf));
   done_model sm (.pclk(pclk), .presetn(presetn), .req(direct_scatter_write),
      .ack(scatter_write_ready), .done(scatter_write_done), .lat(ls));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // completion counts and the hang guard
   always @(posedge pclk) begin
      dn <= dn + int'(fetch_done);
      sn <= sn + int'(scatter_write_done);
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         bad_count++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // apb cycle; answer taken in the cycle pready is high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // w counts cycles until inst_ready; 2 when nothing blocks
   task automatic issue(input logic [1:0] c, input logic s, t);
      @(posedge pclk);
      inst_class <= c;
      fetch_lock_stall <= s;
      fetch_lock_take <= t;
      inst_valid <= 1'b1;
      w = 0;
      do begin
         @(posedge pclk);
         w++;
      end while (inst_ready !== 1'b1);
      inst_valid <= 1'b0;
      // effects of the taken instruction are sampled at the next edge
      @(posedge pclk);
   endtask

   task automatic al(input logic [31:0] v, input logic [1:0] op,
                     input logic we, cl, sa);
      result_red <= v;
      cond_flag_compare_op <= op;
      cond_flag_write_enable <= we;
      result_clamp <= cl;
      cond_flag_sel_alpha <= sa;
      issue(CLASS_ALU, 1'b0, 1'b0);
   endtask

   task automatic flow(input logic e);
      issue(CLASS_FLOW, 1'b0, 1'b0);
      chk(branch_cond_valid, 1);
      chk(branch_cond, e);
   endtask

   task automatic close_out();
      if (bad_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, inst_valid, inst_class,
       fetch_lock_stall, fetch_lock_take, result_red, result_alpha,
       result_clamp, cond_flag_sel_alpha, cond_flag_compare_op,
       cond_flag_write_enable, fetch_op, fetch_dest_reg, fetch_source_reg0,
       fetch_source_reg1, fetch_source_reg2, fetch_source_count, sampler_id,
       coords_prescaled, dest_add_loop, source_add_loop, loop_index_var,
       source_swizzle, result_swizzle, colour_write_mask, opacity_write_mask,
       colour_predicate_select, colour_predicate_invert, predicate_bits,
       opacity_predicate_select, opacity_predicate_invert,
       discard_source_data} <= '0;
      lf <= 8'd30;
      ls <= 8'd30;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `REG_CTRL_OFS, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, 8'h0c, 32'h0);
      chk(er, 1'b1);
      // -1.0 then a denormal, through every compare code
      for (int i = 0; i < 8; i++) begin
         al(i[2] ? 32'h00000001 : 32'hbf800000, i[1:0], 1'b1, 1'b0, 1'b0);
         flow(8'h5a >> i);
      end
      al(32'hbf800000, CMP_IS_ZERO, 1'b1, 1'b1, 1'b0);
      flow(1'b1);
      result_alpha <= 32'hbf800000;
      al(32'h0, CMP_IS_NEGATIVE, 1'b1, 1'b0, 1'b1);
      flow(1'b1);
      al(32'hbf800000, CMP_IS_NEGATIVE, 1'b1, 1'b0, 1'b0);
      al(32'h0, CMP_IS_NEGATIVE, 1'b0, 1'b0, 1'b0);
      issue(CLASS_TEX, 1'b0, 1'b0);
      chk(fetch_req_valid, 1'b0);
      flow(1'b1);
      flow(1'b0);
      fetch_op <= FETCH_OP_SAMPLE;
      fetch_dest_reg <= 7'h7e;
      loop_index_var <= 7'h03;
      dest_add_loop <= 1'b1;
      issue(CLASS_TEX, 1'b0, 1'b0);
      chk(fetch_req_dest, 7'h01);
      chk(fetch_req_scale, 1'b1);
      fetch_op <= FETCH_OP_SAMPLE_PROJECTIVE;
      coords_prescaled <= 1'b1;
      issue(CLASS_TEX, 1'b1, 1'b1);
      chk(w, 2);
      chk(fetch_req_project, 1'b1);
      chk(fetch_req_scale, 1'b0);
      apb(1'b0, `REG_STATUS_OFS, 32'h0);
      chk({rd[11:8], rd[3:2]}, 6'h09);
      issue(CLASS_ALU, 1'b1, 1'b0);
      chk(dn, 2);
      issue(CLASS_OUT, 1'b0, 1'b0);
      issue(CLASS_OUT, 1'b1, 1'b1);
      apb(1'b0, `REG_STATUS_OFS, 32'h0);
      chk({rd[19:16], rd[3:2]}, 6'h0b);
      issue(CLASS_ALU, 1'b1, 1'b0);
      chk(sn, 2);
      fetch_op <= FETCH_OP_DISCARD_NEGATIVE;
      discard_source_data <= {96'h0, 32'hbf800000};
      issue(CLASS_TEX, 1'b0, 1'b0);
      chk(processor_disable, 1'b0);
      colour_write_mask <= 3'b001;
      issue(CLASS_TEX, 1'b0, 1'b0);
      chk({processor_disable, fetch_req_valid}, 2'b10);
      apb(1'b1, `REG_CTRL_OFS, 32'h3);
      @(posedge pclk);
      chk(processor_disable, 1'b0);
      fetch_op <= FETCH_OP_DIRECT_READ;
      {sampler_id, source_add_loop, fetch_source_reg0} <= {4'h9, 1'b1, 7'h10};
      issue(CLASS_TEX, 1'b0, 1'b0);
      chk({fetch_req_op, fetch_req_sampler, fetch_req_src0}, 14'h2493);
      issue(CLASS_ALU, 1'b1, 1'b0);
      chk(w, 2);
      close_out();
   end
endmodule
